// ==== design/scir_top.v ====
// Serial transmitter and receiver core with APB register access
// Behaviour
// - Frames carry 8 or 9 data bits; ninth transmit bit supplies bit 8.
// - Enabling the transmitter first sends an all-ones preamble; frames are start, data, stop.
// - Empty flag sets when buffer moves to shifter; may request transmit interrupt.
// - Transmit pin idles high, or low with invert set, whenever no character is shifting.
// - Clearing module enable releases the transmit pin; the receive pin is input only.
// - Send break repeats all-zero characters; afterwards at least one high bit.
// - Receiver sees break as start, all-zero data and low stop position.
// - Break sets framing, full and break flags; clears buffer and ninth bit.
// - Transmitter disable finishes current character; toggling queues one idle.
// - Invert bit flips every transmitted level including idle and break.
// - Complete flag: shifter and buffer empty, no break or idle; may interrupt.
// - Ninth received bit kept in 9-bit mode; copy of bit 7 otherwise.
// - Finished character moves to read buffer, sets full flag, may interrupt.
// - Receiver samples at sixteen times the baud rate.
// - Sample clock resynchronised after start bit and one-to-zero data edges.
// - Start search: low after three highs starts the sixteen-tick count.
// - Start checked at ticks 3, 5, 7; two highs abort, one high is noise.
// - Data bit is majority of ticks 8, 9, 10; disagreement is noise.
// - High start samples at ticks 8, 9, 10 flag noise but keep start.
// - Stop majority low at ticks 8, 9, 10 is framing error; disagreement noise.
// Assumes an APB master on clk; pins are outside clk's domain on input.
`timescale 1ns/100ps
`include "scir_regs.vh"
module scir_top (
  // Clock and reset
  input  wire        clk,
  input  wire        reset_n,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Interrupt requests
  output reg         tx_irq_q,
  output reg         rx_irq_q,
  // Serial pins
  input  wire        serial_in_pin,
  output reg         serial_out_pin,
  output reg         serial_out_oe
);
  localparam [1:0] R_SRCH  = 2'd0;
  localparam [1:0] R_START = 2'd1;
  localparam [1:0] R_DATA  = 2'd2;
  localparam [1:0] R_STOP  = 2'd3;

  // Control registers
  reg  [7:0]  ctrl1_q;
  reg  [7:0]  ctrl2_q;
  reg         tx_ninth_bit_q;
  reg  [15:0] baud_q;
  // Transmit buffer and flags
  reg  [7:0]  tx_buf_q;
  reg         tx_buffer_empty_flag_q;
  reg         tx_complete_flag_q;
  reg         tx_arm_q;
  // Receive buffer and flags
  reg  [7:0]  rx_buf_q;
  reg         rx_ninth_bit_q;
  reg         rx_full_flag_q;
  reg         overrun_flag_q;
  reg         noise_flag_q;
  reg         framing_error_flag_q;
  reg         break_flag_q;
  reg         rx_arm_q;
  // Receiver datapath
  reg         in_meta_q;
  reg         in_sync_q;
  reg         in_last_q;
  reg  [2:0]  hist_q;
  reg  [1:0]  rstate_q;
  reg  [4:0]  rt_q;
  reg  [2:0]  smp_q;
  reg  [3:0]  bit_q;
  reg  [8:0]  rsh_q;
  reg         prev_bit_q;
  reg         char_noise_q;

  wire        module_enable_bit = ctrl1_q[`SCIR_C1_ENABLE];
  wire        tx_invert_bit     = ctrl1_q[`SCIR_C1_INVERT];
  wire        nine_bit_mode     = ctrl1_q[`SCIR_C1_NINE];
  wire        tx_enable_bit     = ctrl2_q[`SCIR_C2_TX_EN];
  wire        rx_enable_bit     = ctrl2_q[`SCIR_C2_RX_EN];
  wire        send_break_bit    = ctrl2_q[`SCIR_C2_BREAK];
  wire        rx_run            = module_enable_bit && rx_enable_bit;

  wire        oversample_clock;
  wire        tx_load;
  wire        tx_busy;
  wire        tx_line;

  // APB access phase decode
  wire        acc     = psel && penable && pready;
  wire        wr      = acc && pwrite;
  wire        rd      = acc && !pwrite;
  wire        hit_c1  = paddr == `SCIR_OFS_CTRL1;
  wire        hit_c2  = paddr == `SCIR_OFS_CTRL2;
  wire        hit_c3  = paddr == `SCIR_OFS_CTRL3;
  wire        hit_s1  = paddr == `SCIR_OFS_STAT1;
  wire        hit_s2  = paddr == `SCIR_OFS_STAT2;
  wire        hit_dt  = paddr == `SCIR_OFS_DATA;
  wire        hit_bd  = paddr == `SCIR_OFS_BAUD;
  wire        mapped  = hit_c1 | hit_c2 | hit_c3 | hit_s1 | hit_s2 | hit_dt | hit_bd;

  // Receiver events
  wire        rt_tick   = oversample_clock && rx_run;
  wire [1:0]  ones_w    = {1'b0, smp_q[1]} + {1'b0, smp_q[0]} + {1'b0, in_sync_q};
  wire        maj_w     = ones_w >= 2'd2;
  wire        split_w   = ones_w != 2'd0 && ones_w != 2'd3;
  wire        fall_w    = in_last_q && !in_sync_q;
  wire        stop_done = rt_tick && rstate_q == R_STOP && rt_q == 5'd10;
  wire [8:0]  char_w    = nine_bit_mode ? rsh_q : {1'b0, rsh_q[8:1]};
  wire        is_break  = stop_done && !maj_w && char_w == 9'h000;
  wire        fresh     = stop_done && !rx_full_flag_q;

  scir_tick u_tick (
    .clk     (clk),
    .reset_n (reset_n),
    .run     (module_enable_bit),
    .divisor (baud_q),
    .tick_q  (oversample_clock)
  );

  scir_tx u_tx (
    .clk       (clk),
    .reset_n   (reset_n),
    .tick      (oversample_clock),
    .mod_en    (module_enable_bit),
    .tx_en     (tx_enable_bit),
    .nine      (nine_bit_mode),
    .brk       (send_break_bit),
    .buf_valid (!tx_buffer_empty_flag_q),
    .buf_data  ({tx_ninth_bit_q, tx_buf_q}),
    .load_q    (tx_load),
    .busy_q    (tx_busy),
    .line_q    (tx_line)
  );

  // APB slave: one wait state, registered answer
  always @(posedge clk) begin
    if (!reset_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !mapped;
      prdata  <= 32'h00000000;
      if (psel && penable && !pready && !pwrite) begin
        if (hit_c1)
          prdata[7:0] <= ctrl1_q;
        if (hit_c2)
          prdata[7:0] <= ctrl2_q;
        if (hit_c3)
          prdata[7:0] <= {rx_ninth_bit_q, tx_ninth_bit_q, 6'h00};
        if (hit_s1)
          prdata[7:0] <= {tx_buffer_empty_flag_q, tx_complete_flag_q, rx_full_flag_q,
                          1'b0, overrun_flag_q, noise_flag_q, framing_error_flag_q, 1'b0};
        if (hit_s2)
          prdata[7:0] <= {6'h00, break_flag_q, rstate_q != R_SRCH};
        if (hit_dt)
          prdata[7:0] <= rx_buf_q;
        if (hit_bd)
          prdata[15:0] <= baud_q;
      end
    end
  end

  // Control registers
  always @(posedge clk) begin
    if (!reset_n) begin
      ctrl1_q        <= `SCIR_RST_CTRL;
      ctrl2_q        <= `SCIR_RST_CTRL;
      tx_ninth_bit_q <= 1'b0;
      baud_q         <= `SCIR_RST_BAUD;
      tx_buf_q       <= 8'h00;
    end else if (wr) begin
      if (hit_c1)
        ctrl1_q <= pwdata[7:0];
      if (hit_c2)
        ctrl2_q <= pwdata[7:0];
      if (hit_c3)
        tx_ninth_bit_q <= pwdata[`SCIR_C3_TX9];
      if (hit_bd)
        baud_q <= pwdata[15:0];
      if (hit_dt && tx_arm_q)
        tx_buf_q <= pwdata[7:0];
    end
  end

  // Transmit flags; the load wins over a clearing write
  always @(posedge clk) begin
    if (!reset_n) begin
      tx_buffer_empty_flag_q <= 1'b1;
      tx_complete_flag_q     <= 1'b1;
      tx_arm_q               <= 1'b0;
    end else begin
      if (rd && hit_s1 && tx_buffer_empty_flag_q)
        tx_arm_q <= 1'b1;
      else if (wr && hit_dt)
        tx_arm_q <= 1'b0;
      if (tx_load)
        tx_buffer_empty_flag_q <= 1'b1;
      else if (wr && hit_dt && tx_arm_q)
        tx_buffer_empty_flag_q <= 1'b0;
      tx_complete_flag_q <= !tx_busy && tx_buffer_empty_flag_q &&
                            !(wr && hit_dt && tx_arm_q);
    end
  end

  // Interrupt requests and pin drive
  always @(posedge clk) begin
    if (!reset_n) begin
      tx_irq_q       <= 1'b0;
      rx_irq_q       <= 1'b0;
      serial_out_pin <= 1'b1;
      serial_out_oe  <= 1'b0;
    end else begin
      tx_irq_q <= (tx_buffer_empty_flag_q && ctrl2_q[`SCIR_C2_TXE_IE]) ||
                  (tx_complete_flag_q && ctrl2_q[`SCIR_C2_TC_IE]);
      rx_irq_q <= rx_full_flag_q && ctrl2_q[`SCIR_C2_RXF_IE];
      serial_out_pin <= tx_line ^ tx_invert_bit;
      serial_out_oe  <= module_enable_bit;
    end
  end

  // Receive pin synchroniser
  always @(posedge clk) begin
    if (!reset_n) begin
      in_meta_q <= 1'b1;
      in_sync_q <= 1'b1;
    end else begin
      in_meta_q <= serial_in_pin;
      in_sync_q <= in_meta_q;
    end
  end

  // Receive bit recovery
  always @(posedge clk) begin
    if (!reset_n || !rx_run) begin
      rstate_q     <= R_SRCH;
      hist_q       <= 3'h0;
      in_last_q    <= 1'b1;
      rt_q         <= 5'd0;
      smp_q        <= 3'h0;
      bit_q        <= 4'h0;
      rsh_q        <= 9'h000;
      prev_bit_q   <= 1'b1;
      char_noise_q <= 1'b0;
    end else if (rt_tick) begin
      in_last_q <= in_sync_q;
      rt_q      <= rt_q + 5'd1;
      case (rstate_q)
        R_SRCH: begin
          hist_q <= {hist_q[1:0], in_sync_q};
          if (hist_q == 3'h7 && !in_sync_q) begin
            rstate_q     <= R_START;
            rt_q         <= 5'd2;
            char_noise_q <= 1'b0;
          end
        end
        R_START: begin
          if (rt_q == 5'd3 || rt_q == 5'd5)
            smp_q <= {smp_q[1:0], in_sync_q};
          if (rt_q == 5'd8 || rt_q == 5'd9)
            smp_q <= {smp_q[1:0], in_sync_q};
          if (rt_q == 5'd7) begin
            smp_q <= 3'h0;
            if (ones_w >= 2'd2) begin
              rstate_q <= R_SRCH;
              hist_q   <= 3'h0;
            end else if (ones_w != 2'd0)
              char_noise_q <= 1'b1;
          end
          if (rt_q == 5'd10 && ones_w != 2'd0)
            char_noise_q <= 1'b1;
          if (rt_q == `SCIR_RT_LAST) begin
            rstate_q   <= R_DATA;
            rt_q       <= 5'd1;
            bit_q      <= 4'h0;
            prev_bit_q <= 1'b0;
          end
        end
        R_DATA: begin
          if (rt_q == 5'd8 || rt_q == 5'd9)
            smp_q <= {smp_q[1:0], in_sync_q};
          if (rt_q == 5'd10) begin
            rsh_q      <= {maj_w, rsh_q[8:1]};
            prev_bit_q <= maj_w;
            if (split_w)
              char_noise_q <= 1'b1;
          end
          if (fall_w && prev_bit_q && rt_q >= 5'd12) begin
            rt_q  <= 5'd2;
            bit_q <= bit_q + 4'h1;
            if (bit_q == (nine_bit_mode ? 4'h8 : 4'h7))
              rstate_q <= R_STOP;
          end else if (fall_w && prev_bit_q && rt_q <= 5'd4 && bit_q != 4'h0)
            rt_q <= 5'd2;
          else if (rt_q == `SCIR_RT_LAST) begin
            rt_q  <= 5'd1;
            bit_q <= bit_q + 4'h1;
            if (bit_q == (nine_bit_mode ? 4'h8 : 4'h7))
              rstate_q <= R_STOP;
          end
        end
        R_STOP: begin
          if (rt_q == 5'd8 || rt_q == 5'd9)
            smp_q <= {smp_q[1:0], in_sync_q};
          if (rt_q == 5'd10) begin
            rstate_q <= R_SRCH;
            hist_q   <= 3'h0;
          end
        end
        default: rstate_q <= R_SRCH;
      endcase
    end
  end

  // Receive buffer and flags; hardware sets win over the clear sequence
  always @(posedge clk) begin
    if (!reset_n) begin
      rx_buf_q             <= 8'h00;
      rx_ninth_bit_q       <= 1'b0;
      rx_full_flag_q       <= 1'b0;
      overrun_flag_q       <= 1'b0;
      noise_flag_q         <= 1'b0;
      framing_error_flag_q <= 1'b0;
      break_flag_q         <= 1'b0;
      rx_arm_q             <= 1'b0;
    end else begin
      if (rd && hit_s1)
        rx_arm_q <= 1'b1;
      else if (rd && hit_dt)
        rx_arm_q <= 1'b0;
      if (rd && hit_dt && rx_arm_q) begin
        rx_full_flag_q       <= 1'b0;
        overrun_flag_q       <= 1'b0;
        noise_flag_q         <= 1'b0;
        framing_error_flag_q <= 1'b0;
        break_flag_q         <= 1'b0;
      end
      if (stop_done) begin
        rx_full_flag_q <= 1'b1;
        if (!maj_w)
          framing_error_flag_q <= 1'b1;
        if (split_w || char_noise_q)
          noise_flag_q <= 1'b1;
        if (!fresh)
          overrun_flag_q <= 1'b1;
      end
      if (is_break) begin
        break_flag_q   <= 1'b1;
        rx_buf_q       <= 8'h00;
        rx_ninth_bit_q <= 1'b0;
      end else if (fresh) begin
        rx_buf_q       <= char_w[7:0];
        rx_ninth_bit_q <= nine_bit_mode ? char_w[8] : char_w[7];
      end
    end
  end
endmodule // scir_top

// ==== design/scir_regs.vh ====
// Register offsets, field positions, reset values and timing counts
// Assumes 32-bit APB data, one aligned word per register
`ifndef SCIR_REGS_VH
`define SCIR_REGS_VH
`define SCIR_OFS_CTRL1     8'h00
`define SCIR_OFS_CTRL2     8'h04
`define SCIR_OFS_CTRL3     8'h08
`define SCIR_OFS_STAT1     8'h0c
`define SCIR_OFS_STAT2     8'h10
`define SCIR_OFS_DATA      8'h14
`define SCIR_OFS_BAUD      8'h18
`define SCIR_C1_ENABLE     6
`define SCIR_C1_INVERT     5
`define SCIR_C1_NINE       4
`define SCIR_C2_TXE_IE     7
`define SCIR_C2_TC_IE      6
`define SCIR_C2_RXF_IE     5
`define SCIR_C2_TX_EN      3
`define SCIR_C2_RX_EN      2
`define SCIR_C2_BREAK      0
`define SCIR_C3_RX9        7
`define SCIR_C3_TX9        6
`define SCIR_S1_TXE        7
`define SCIR_S1_TC         6
`define SCIR_S1_RXF        5
`define SCIR_S1_OVR        3
`define SCIR_S1_NOISE      2
`define SCIR_S1_FRAME      1
`define SCIR_S1_PARITY     0
`define SCIR_S2_BREAK      1
`define SCIR_S2_BUSY       0
`define SCIR_RST_CTRL      8'h00
`define SCIR_RST_BAUD      16'h0082
`define SCIR_OVERSAMPLE    5'h10
`define SCIR_RT_LAST       5'h10
`endif

// ==== design/scir_tick.v ====
// Oversample tick divider: one-cycle enable at sixteen times the baud rate
// Assumes divisor from a register on the same clock
`timescale 1ns/100ps
module scir_tick (
  // Clock and reset
  input  wire        clk,
  input  wire        reset_n,
  // Control
  input  wire        run,
  input  wire [15:0] divisor,
  // Tick out
  output reg         tick_q
);
  reg [15:0] cnt_q;

  always @(posedge clk) begin
    if (!reset_n || !run) begin
      cnt_q  <= 16'h0000;
      tick_q <= 1'b0;
    end else if (cnt_q >= divisor) begin
      cnt_q  <= 16'h0000;
      tick_q <= 1'b1;
    end else begin
      cnt_q  <= cnt_q + 16'h0001;
      tick_q <= 1'b0;
    end
  end
endmodule // scir_tick

// ==== design/scir_tx.v ====
// Transmit shifter: preamble, data frames, break and idle characters
// Assumes tick is a one-cycle pulse at sixteen times the baud rate
`timescale 1ns/100ps
`include "scir_regs.vh"
module scir_tx (
  // Clock and reset
  input  wire       clk,
  input  wire       reset_n,
  // Control
  input  wire       tick,
  input  wire       mod_en,
  input  wire       tx_en,
  input  wire       nine,
  input  wire       brk,
  // Buffer side
  input  wire       buf_valid,
  input  wire [8:0] buf_data,
  output reg        load_q,
  output reg        busy_q,
  // Line before inversion
  output reg        line_q
);
  reg [10:0] sr_q;
  reg [3:0]  left_q;
  reg [3:0]  sub_q;
  reg        pre_q;
  reg        was_brk_q;
  wire       edge_w = tick && (!busy_q || sub_q == 4'hf);
  wire       last_w = left_q <= 4'h1;

  always @(posedge clk) begin
    load_q <= 1'b0;
    if (!reset_n || !mod_en) begin
      sr_q      <= 11'h7ff;
      left_q    <= 4'h0;
      sub_q     <= 4'h0;
      busy_q    <= 1'b0;
      pre_q     <= 1'b1;
      was_brk_q <= 1'b0;
      line_q    <= 1'b1;
    end else begin
      if (!tx_en)
        pre_q <= 1'b1;
      if (tick)
        sub_q <= sub_q + 4'h1;
      if (edge_w && busy_q && !last_w) begin
        sr_q   <= {1'b1, sr_q[10:1]};
        left_q <= left_q - 4'h1;
        line_q <= sr_q[1];
      end else if (edge_w) begin
        // First bit of a character also lasts a full sixteen ticks
        sub_q <= 4'h0;
        if (tx_en && brk) begin
          sr_q      <= 11'h000;
          left_q    <= nine ? 4'hb : 4'ha;
          busy_q    <= 1'b1;
          was_brk_q <= 1'b1;
          line_q    <= 1'b0;
        end else if (was_brk_q) begin
          sr_q      <= 11'h7ff;
          left_q    <= 4'h1;
          busy_q    <= 1'b1;
          was_brk_q <= 1'b0;
          line_q    <= 1'b1;
        end else if (tx_en && pre_q) begin
          sr_q   <= 11'h7ff;
          left_q <= nine ? 4'hb : 4'ha;
          busy_q <= 1'b1;
          pre_q  <= 1'b0;
          line_q <= 1'b1;
        end else if (tx_en && buf_valid) begin
          sr_q <= nine ? {1'b1, buf_data, 1'b0}
                       : {2'b11, buf_data[7:0], 1'b0};
          left_q <= nine ? 4'hb : 4'ha;
          busy_q <= 1'b1;
          load_q <= 1'b1;
          line_q <= 1'b0;
        end else begin
          busy_q <= 1'b0;
          line_q <= 1'b1;
        end
      end
    end
  end
endmodule // scir_tx

// ==== verification/scir_chk.sv ====
// Checker for the serial core: APB handshake, pin release, idle level, irq gating
// Assumes it is bound to scir_top and sees only its ports
`timescale 1ns/100ps
`include "scir_regs.vh"
module scir_chk (
  // Clock and reset
  input wire logic        clk,
  input wire logic        reset_n,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Interrupts
  input wire logic        tx_irq_q,
  input wire logic        rx_irq_q,
  // Serial pins
  input wire logic        serial_in_pin,
  input wire logic        serial_out_pin,
  input wire logic        serial_out_oe
);
  logic       en_q, inv_q, txeie_q, tx_complete_irq_enable_q, rxie_q;
  logic [1:0] quiet_q;
  wire        wr_done = psel && penable && pwrite && pready && !pslverr;
  wire        wr_c1   = wr_done && paddr == `SCIR_OFS_CTRL1;

  // Shadow of control bits, and settle count since last ctrl1 write
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      {en_q, inv_q, txeie_q, tx_complete_irq_enable_q, rxie_q} <= 5'h00;
      quiet_q <= 2'h0;
    end else begin
      quiet_q <= wr_c1 ? 2'h0 : ((quiet_q == 2'h3) ? quiet_q : quiet_q + 2'h1);
      if (wr_c1)
        {en_q, inv_q} <= {pwdata[`SCIR_C1_ENABLE], pwdata[`SCIR_C1_INVERT]};
      if (wr_done && paddr == `SCIR_OFS_CTRL2)
        {txeie_q, tx_complete_irq_enable_q, rxie_q} <= pwdata[7:5];
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  pready_pulse_a: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  pready_cause_a: assert property (pready |-> $past(psel && penable))
    else $error("pready without an access phase");
  wait_state_a: assert property ((psel && penable && !$past(penable)) |-> !pready ##1 pready)
    else $error("answer not after exactly one wait state");
  unmapped_err_a: assert property (pready |-> pslverr == (paddr > `SCIR_OFS_BAUD))
    else $error("slave error does not match address map");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
    else $error("read data not zero outside answer");
  oe_release_a: assert property ((quiet_q == 2'h3) |-> serial_out_oe == en_q)
    else $error("pin enable does not follow module enable");
  idle_level_a: assert property ((quiet_q == 2'h3 && !en_q) |-> serial_out_pin == !inv_q)
    else $error("disabled transmit pin not at idle level");
  rx_irq_gate_a: assert property ($rose(rx_irq_q) |-> $past(rxie_q))
    else $error("receive request while masked");
  tx_irq_gate_a: assert property ($rose(tx_irq_q) |-> $past(txeie_q || tx_complete_irq_enable_q))
    else $error("transmit request while masked");
endmodule // scir_chk

bind scir_top scir_chk u_chk (.clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .pready, .pslverr, .tx_irq_q, .rx_irq_q, .serial_in_pin, .serial_out_pin,
  .serial_out_oe);

// ==== verification/scir_peer.sv ====
// Remote serial device: sends frames, breaks and glitches, captures frames
// Assumes bit time is a whole number of bench clocks
`timescale 1ns/100ps
module scir_peer #(
  parameter int BIT_CLKS = 32
) (
  // Clock
  input  wire logic clk,
  // Serial lines
  input  wire logic line_in,
  output logic      line_out
);
  initial line_out = 1'b1;

  // Start low, data LSB first, then stop level; low stop with all-zero data makes a break
  task automatic send(input logic [8:0] d, input int nb, input logic stop);
    line_out <= 1'b0;
    repeat (BIT_CLKS) @(posedge clk);
    for (int i = 0; i < nb; i++) begin
      line_out <= d[i];
      repeat (BIT_CLKS) @(posedge clk);
    end
    line_out <= stop;
    repeat (BIT_CLKS) @(posedge clk);
    line_out <= 1'b1;
  endtask

  // Samples mid-bit after the first falling edge; w is the wait for it
  task automatic recv(input int nb, output logic [9:0] d, output int w);
    d = 10'h0;
    w = 0;
    while (line_in !== 1'b0) begin
      @(posedge clk);
      w++;
    end
    repeat (BIT_CLKS / 2) @(posedge clk);
    for (int i = 0; i <= nb; i++) begin
      repeat (BIT_CLKS) @(posedge clk);
      d[i] = line_in;
    end
  endtask

  task automatic glitch(input int n);
    line_out <= 1'b0;
    repeat (n) @(posedge clk);
    line_out <= 1'b1;
  endtask
endmodule // scir_peer

// ==== verification/testbench.sv ====
// Testbench for the serial core: APB master, remote peer, directed scenarios
// Assumes scir_top, scir_peer and the bound checker are compiled alongside
`timescale 1ns/100ps
`include "scir_regs.vh"
module testbench;
  localparam int BIT_CLKS = 32;
  logic        clk, reset_n, psel, penable, pwrite, pready, pslverr, err;
  logic        tx_irq_q, rx_irq_q, rx_line, tx_line, tx_oe;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  int          bad_count = 0;
  int          checked = 0;
  int          cyc = 0;
  wire         tx_wire = tx_oe ? tx_line : 1'b1;

  scir_top u_dut (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tx_irq_q(tx_irq_q), .rx_irq_q(rx_irq_q), .serial_in_pin(rx_line),
    .serial_out_pin(tx_line), .serial_out_oe(tx_oe));
  scir_peer #(.BIT_CLKS(BIT_CLKS)) u_peer (.clk(clk), .line_in(tx_wire), .line_out(rx_line));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] r);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rd);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0, rd);
    chk(rd & m, e);
  endtask

  task automatic t_reset();
    rdc(`SCIR_OFS_STAT1, 32'hff, 32'hc0);
    rdc(`SCIR_OFS_CTRL1, 32'hffffffff, 32'h0);
    rdc(`SCIR_OFS_BAUD, 32'hffffffff, 32'h82);
    apb(1'b0, 8'h1c, 32'h0, rd);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
  endtask

  task automatic t_tx(input logic nine, input logic [8:0] d);
    logic [9:0] got;
    int         t0, t1, w;
    wr(`SCIR_OFS_CTRL1, nine ? 32'h50 : 32'h40);
    wr(`SCIR_OFS_CTRL3, {25'h0, d[8], 6'h0});
    wr(`SCIR_OFS_CTRL2, 32'h24);
    wr(`SCIR_OFS_CTRL2, 32'h2c);
    t0 = cyc;
    apb(1'b0, `SCIR_OFS_STAT1, 32'h0, rd);
    wr(`SCIR_OFS_DATA, {24'h0, d[7:0]});
    t1 = cyc;
    u_peer.recv(nine ? 9 : 8, got, w);
    chk({31'h0, t1 - t0 + w + 2 >= (nine ? 11 : 10) * BIT_CLKS}, 32'h1);
    chk({22'h0, got}, nine ? {22'h0, 1'b1, d} : {22'h0, 2'b01, d[7:0]});
    repeat (2 * BIT_CLKS) @(posedge clk);
    rdc(`SCIR_OFS_STAT1, 32'hc0, 32'hc0);
    wr(`SCIR_OFS_CTRL2, 32'h6c);
    repeat (3) @(posedge clk);
    chk({31'h0, tx_irq_q}, 32'h1);
    wr(`SCIR_OFS_CTRL2, 32'h2c);
    repeat (3) @(posedge clk);
    chk({31'h0, tx_irq_q}, 32'h0);
  endtask

  task automatic t_rx(input logic nine, input logic [8:0] d, input logic stop);
    int n;
    wr(`SCIR_OFS_CTRL1, nine ? 32'h50 : 32'h40);
    u_peer.send(d, nine ? 9 : 8, stop);
    n = 0;
    while (rx_irq_q !== 1'b1 && n < 4 * BIT_CLKS) begin
      @(posedge clk);
      n++;
    end
    chk({31'h0, rx_irq_q}, 32'h1);
    rdc(`SCIR_OFS_STAT2, 32'h2, stop ? 32'h0 : 32'h2);
    rdc(`SCIR_OFS_CTRL3, 32'h80, {24'h0, nine ? d[8] : d[7], 7'h0});
    rdc(`SCIR_OFS_STAT1, stop ? 32'h2e : 32'h22, stop ? 32'h20 : 32'h22);
    rdc(`SCIR_OFS_DATA, 32'hffffffff, {24'h0, d[7:0]});
    repeat (3) @(posedge clk);
    chk({31'h0, rx_irq_q}, 32'h0);
  endtask

  task automatic t_glitch();
    u_peer.glitch(4);
    repeat (12 * BIT_CLKS) @(posedge clk);
    rdc(`SCIR_OFS_STAT1, 32'h20, 32'h0);
  endtask

  task automatic t_tx_break();
    int n;
    wr(`SCIR_OFS_CTRL2, 32'h2d);
    repeat (2 * BIT_CLKS) @(posedge clk);
    rdc(`SCIR_OFS_STAT1, 32'h40, 32'h0);
    for (n = 0; n < 8; n++) begin
      repeat (BIT_CLKS) @(posedge clk);
      chk({31'h0, tx_line}, 32'h0);
    end
    wr(`SCIR_OFS_CTRL2, 32'h2c);
    n = 0;
    while (tx_line !== 1'b1 && n < 12 * BIT_CLKS) begin
      @(posedge clk);
      n++;
    end
    repeat (BIT_CLKS - 4) @(posedge clk);
    chk({31'h0, tx_line}, 32'h1);
  endtask

  // Enable toggled while a character shifts: one idle character before the next
  task automatic t_idle_queue();
    logic [9:0] got;
    int         w;
    apb(1'b0, `SCIR_OFS_STAT1, 32'h0, rd);
    wr(`SCIR_OFS_DATA, 32'h3c);
    fork
      u_peer.recv(8, got, w);
      begin
        do apb(1'b0, `SCIR_OFS_STAT1, 32'h0, rd); while (rd[7] !== 1'b1);
        wr(`SCIR_OFS_CTRL2, 32'h24);
        wr(`SCIR_OFS_CTRL2, 32'h2c);
        wr(`SCIR_OFS_DATA, 32'hc3);
      end
    join
    chk({22'h0, got}, {22'h0, 2'b01, 8'h3c});
    u_peer.recv(8, got, w);
    chk({31'h0, w > 9 * BIT_CLKS}, 32'h1);
    chk({22'h0, got}, {22'h0, 2'b01, 8'hc3});
  endtask

  task automatic t_disable();
    wr(`SCIR_OFS_CTRL1, 32'h20);
    repeat (4) @(posedge clk);
    chk({31'h0, tx_oe}, 32'h0);
    chk({31'h0, tx_line}, 32'h0);
    wr(`SCIR_OFS_CTRL1, 32'h00);
    repeat (4) @(posedge clk);
    chk({31'h0, tx_line}, 32'h1);
  endtask

  task automatic results();
    $display("checked=%0d bad_count=%0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge clk);
    bad_count++;
    results();
  end

  initial begin
    reset_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    t_reset();
    wr(`SCIR_OFS_BAUD, 32'h1);
    t_tx(1'b0, 9'h0a5);
    t_tx(1'b1, 9'h13c);
    t_rx(1'b0, 9'h096, 1'b1);
    t_rx(1'b1, 9'h155, 1'b1);
    t_rx(1'b0, 9'h000, 1'b0);
    t_glitch();
    t_tx_break();
    t_idle_queue();
    t_disable();
    results();
  end
endmodule // testbench
